// file: trace_sink_model.sv
/*
  Trace macrocell model: raises the enable on request and tracks waypoints.
  Assumes one core lane on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module trace_sink_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       want_i,
  // Port side
  input  wire logic       valid_i,
  input  wire logic [1:0] commit_i,
  input  wire logic       discard_i,
  output logic            enable_o,
  output var int          seen_o,
  output var int          pend_o
);
  int seen_q = 0;
  int pend_q = 0;
  assign enable_o = want_i;
  assign seen_o   = seen_q;
  assign pend_o   = pend_q;
  // A waypoint shown and committed in one cycle nets to zero pending.
  always @(posedge clk_i) begin
    seen_q <= seen_q + int'(valid_i);
    if (discard_i) begin
      pend_q <= 0;
    end else begin
      pend_q <= pend_q + int'(valid_i) - int'(commit_i);
    end
  end
endmodule : trace_sink_model
`default_nettype wire

// file: waypoint_trace_output_port.sv
/*
  Waypoint trace output port, one lane per core. Each lane takes waypoints
  from its core through a two-entry buffer, presents them to the trace
  macrocell, and tracks the speculative ones until commit or flush.
  Assumes core-side signals are on clk_i; the enable from the macrocell
  arrives from another domain and is synchronised here.
*/
// Notes on behaviour
// (R1) Every core gets its own independent copy of all waypoint outputs.
// (R2) Waypoints leave only while the macrocell holds waypoint_out_enable high; the enable synchroniser lets them leave up to two cycles after it drops.
// (R3) spec_fifo_empty is high whenever no presented waypoint awaits resolution.
// (R4) commit_count gives how many pending waypoints commit in that cycle.
// (R5) A waypoint may be shown valid and counted committed in the same cycle.
// (R6) Each waypoint carries its context_tag whatever its condition result.
// (R7) exc_kind_code uses the fixed four-bit encoding of exception kinds.
// (R8) discard_uncommitted flushes every waypoint not yet committed; a word offered in the flush cycle is still kept in the buffer.
// (R9) link_update_flag marks a branch that writes the link register.
// (R10) link_update_flag is high only for direct or indirect branch kinds.
// (R11) Commits and flushes retire pending waypoints oldest first.
`timescale 1ns/1ps
`default_nettype none
module waypoint_trace_output_port #(
  parameter int CORES = wpt_pkg::NUM_CORES,
  parameter int PEND  = wpt_pkg::PEND_DEPTH
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  // Core side
  input  wire logic [CORES-1:0]              core_valid_i,
  input  wire wpt_pkg::waypoint_t [CORES-1:0] core_wpt_i,
  output logic [CORES-1:0]                   core_ready_o,
  input  wire logic [CORES-1:0]              core_commit_i,
  input  wire logic [CORES-1:0]              core_flush_i,
  // Trace macrocell side
  input  wire logic [CORES-1:0]              waypoint_out_enable_i,
  output logic [CORES-1:0]                   waypoint_valid_o,
  output logic [CORES-1:0][2:0]              waypoint_kind_o,
  output logic [CORES-1:0][31:0]             context_tag_o,
  output logic [CORES-1:0][3:0]              exc_kind_code_o,
  output logic [CORES-1:0]                   link_update_flag_o,
  output logic [CORES-1:0]                   spec_fifo_empty_o,
  output logic [CORES-1:0][1:0]              commit_count_o,
  output logic [CORES-1:0]                   discard_uncommitted_o
);

  localparam int PW = $clog2(PEND + 1);

  // ----------------------------------------------------------------------
  // Per-core lanes
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < CORES; c++) begin : g_lane // (R1)
    logic                 en_meta;
    logic                 en_sync;
    wpt_pkg::waypoint_t   buf_q [wpt_pkg::BUF_DEPTH];
    logic                 wr_ptr;
    logic                 rd_ptr;
    logic [1:0]           fill;
    logic [PW-1:0]        pend;
    logic                 out_valid;
    wpt_pkg::waypoint_t   out_wpt;
    wpt_pkg::waypoint_t   head;
    logic [1:0]           commit_q;
    logic                 flush_q;
    wire                  buf_full  = (fill == 2'(wpt_pkg::BUF_DEPTH));
    wire                  buf_empty = (fill == 2'h0);
    // Presentation stops at PEND pending waypoints, so the count never wraps.
    wire                  pend_room = (pend < PW'(PEND));
    // The macrocell may stall by dropping its enable; the buffer keeps words.
    wire                  pop       = !buf_empty && en_sync && pend_room; // (R2)
    wire                  push      = core_valid_i[c] && !buf_full;
    // Commit is counted against the pending total including this cycle's
    // presentation, so a word can be shown and committed together.
    wire [PW-1:0]         avail     = pend + PW'(pop); // (R5)
    wire                  do_commit = core_commit_i[c] && (avail != '0) && !core_flush_i[c];
    wire [2:0]            k         = head.kind;
    wire                  is_branch = (k == wpt_pkg::KIND_DIRECT) ||
                                      (k == wpt_pkg::KIND_INDIRECT);
    wire [PW-1:0]         next_pend = core_flush_i[c] ? '0 : avail - PW'(do_commit); // (R8)

    assign core_ready_o[c] = !buf_full;
    assign head            = buf_q[rd_ptr];

    // --------------------------------------------------------------------
    // Enable synchroniser
    // --------------------------------------------------------------------
    // The enable comes from the macrocell's clock, so two flops guard it.
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        en_meta <= 1'b0;
        en_sync <= 1'b0;
      end else begin
        en_meta <= waypoint_out_enable_i[c];
        en_sync <= en_meta;
      end
    end

    // --------------------------------------------------------------------
    // Input buffer
    // --------------------------------------------------------------------
    // A flush drops buffered words as well: they are uncommitted, and no later
    // commit could refer to them. A word offered in the flush cycle is kept.
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        wr_ptr <= 1'b0;
        rd_ptr <= 1'b0;
        fill   <= 2'h0;
        buf_q  <= '{default: '0};
      end else begin
        if (push) begin
          buf_q[wr_ptr] <= core_wpt_i[c];
          wr_ptr        <= !wr_ptr;
        end
        if (core_flush_i[c]) begin // (R8)
          rd_ptr <= wr_ptr;
          fill   <= {1'b0, push};
        end else begin
          if (pop) begin
            rd_ptr <= !rd_ptr;
          end
          fill <= fill + 2'(push) - 2'(pop);
        end
      end
    end

    // --------------------------------------------------------------------
    // Presentation, pending count and strobes
    // --------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        out_valid <= 1'b0;
        out_wpt   <= '0;
        pend      <= '0;
        commit_q  <= wpt_pkg::COMMIT_RESET;
        flush_q   <= 1'b0;
      end else begin
        // A word popped during a flush is dropped, never shown.
        out_valid <= pop && !core_flush_i[c]; // (R8)
        if (pop) begin
          out_wpt             <= head; // (R6) (R7)
          out_wpt.writes_link <= head.writes_link && is_branch; // (R9) (R10)
        end
        pend     <= next_pend; // (R11)
        commit_q <= {1'b0, do_commit}; // (R4)
        flush_q  <= core_flush_i[c];
      end
    end

    // --------------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------------
    assign waypoint_valid_o[c]      = out_valid;
    assign waypoint_kind_o[c]       = out_wpt.kind;
    assign context_tag_o[c]         = out_wpt.context_tag;
    assign exc_kind_code_o[c]       = out_wpt.exc_code;
    assign link_update_flag_o[c]    = out_wpt.writes_link;
    assign spec_fifo_empty_o[c]     = (pend == '0); // (R3)
    assign commit_count_o[c]        = commit_q;
    assign discard_uncommitted_o[c] = flush_q;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    a_valid_needs_en: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R2)
      out_valid |-> $past(en_sync)) else $error("Waypoint output without enable.");
    a_empty_tracks_pend: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R3)
      (pop && !core_flush_i[c] && !core_commit_i[c]) |=> !spec_fifo_empty_o[c])
      else $error("Pending waypoint while empty flag high.");
    a_commit_count: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R4)
      (core_commit_i[c] && !core_flush_i[c] && avail != '0) |=> commit_count_o[c] == 2'h1)
      else $error("Commit count does not match commit.");
    a_same_cycle: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R5)
      (pend == '0 && pop && core_commit_i[c] && !core_flush_i[c]) |=>
        (waypoint_valid_o[c] && commit_count_o[c] == 2'h1 && spec_fifo_empty_o[c]))
      else $error("Same-cycle valid and commit lost.");
    a_flush_clears: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R8)
      core_flush_i[c] |=> (discard_uncommitted_o[c] && spec_fifo_empty_o[c]))
      else $error("Flush left pending waypoints.");
    a_link_kind: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R10)
      link_update_flag_o[c] |-> (waypoint_kind_o[c] == wpt_pkg::KIND_DIRECT ||
                                 waypoint_kind_o[c] == wpt_pkg::KIND_INDIRECT))
      else $error("Link flag on a non-branch kind.");
    a_link_passes: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R9)
      (pop && is_branch && buf_q[rd_ptr].writes_link) |=> link_update_flag_o[c])
      else $error("Link-writing branch lost its flag.");
    a_tag_carried: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R6)
      pop |=> context_tag_o[c] == $past(head.context_tag))
      else $error("Context tag not carried.");
    a_code_carried: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R7)
      pop |=> exc_kind_code_o[c] == $past(head.exc_code))
      else $error("Exception code altered.");
    a_pend_order: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R11)
      (!pop && do_commit) |=> pend == $past(pend) - PW'(1))
      else $error("Commit did not retire one oldest waypoint.");
    a_pend_grows: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R11)
      (pop && !do_commit && !core_flush_i[c]) |=> pend == $past(pend) + PW'(1))
      else $error("Presented waypoint not added to pending.");
    a_pend_limit: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R3)
      pend <= PW'(PEND))
      else $error("Pending count beyond its limit.");
    a_flush_hides: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R8)
      core_flush_i[c] |=> !waypoint_valid_o[c])
      else $error("Waypoint shown in the cycle of a flush.");
    a_flush_buffer: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R8)
      core_flush_i[c] |=> fill == {1'b0, $past(push)})
      else $error("Flush left buffered waypoints.");
    a_enable_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R2)
      (!waypoint_out_enable_i[c] [*3]) |=> !waypoint_valid_o[c])
      else $error("Waypoint output after enable dropped.");
    a_commit_idle: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R4)
      (!core_commit_i[c] || core_flush_i[c]) |=> commit_count_o[c] == 2'h0)
      else $error("Commit count without an accepted commit.");
    a_kind_carried: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R10)
      pop |=> waypoint_kind_o[c] == $past(head.kind))
      else $error("Waypoint kind altered.");
  end

endmodule : waypoint_trace_output_port
`default_nettype wire

// file: waypoint_trace_output_port_tb_top.sv
/*
  Self-checking bench for the waypoint trace output port, one core lane.
  Assumes the package, the port and the sink model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module waypoint_trace_output_port_tb_top;
  logic                     clk_i = 1'b0;
  logic                     nrst_i = 1'b0;
  logic [0:0]               valid, ready, commit, flush, want, en, wv, link, empty, disc;
  wpt_pkg::waypoint_t [0:0] wpt;
  logic [0:0][2:0]          kind;
  logic [0:0][31:0]         tag;
  logic [0:0][3:0]          code;
  logic [0:0][1:0]          cc;
  int                       seen, pend;
  int                       failures = 0;
  int                       checks = 0;
  always #5 clk_i = ~clk_i;
  waypoint_trace_output_port u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .core_valid_i(valid),
    .core_wpt_i(wpt), .core_ready_o(ready), .core_commit_i(commit), .core_flush_i(flush),
    .waypoint_out_enable_i(en), .waypoint_valid_o(wv), .waypoint_kind_o(kind),
    .context_tag_o(tag), .exc_kind_code_o(code), .link_update_flag_o(link),
    .spec_fifo_empty_o(empty), .commit_count_o(cc), .discard_uncommitted_o(disc));
  trace_sink_model u_sink (.clk_i(clk_i), .want_i(want[0]), .valid_i(wv[0]),
    .commit_i(cc[0]), .discard_i(disc[0]), .enable_o(en[0]), .seen_o(seen), .pend_o(pend));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic push(input logic [2:0] k, input logic [3:0] c, input logic l);
    int n;
    n = 0;
    @(negedge clk_i);
    valid = 1'b1;
    wpt[0] = '{k, 32'h0000_1000 + c, c, l};
    // The offer stands until the buffer has room at the coming edge.
    while (ready[0] !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    valid = 1'b0;
  endtask : push
  task automatic take(input logic [2:0] k, input logic [3:0] c, input logic l, input logic cm);
    int n;
    n = 0;
    while (wv[0] !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk(wv, 1'b1);
    chk(kind, k);
    chk(tag, 32'h0000_1000 + c);
    chk(code, c);
    chk(link, l && (k == wpt_pkg::KIND_DIRECT || k == wpt_pkg::KIND_INDIRECT));
    chk(empty, 1'b0);
    commit = cm;
    @(negedge clk_i);
    commit = 1'b0;
    chk(cc, {1'b0, cm});
  endtask : take
  // The enable gates output; two held words fill the buffer; a flush empties all.
  task automatic gate_flush();
    want = 1'b0;
    push(wpt_pkg::KIND_DIRECT, 4'h0, 1'b1);
    push(wpt_pkg::KIND_INDIRECT, 4'h0, 1'b1);
    chk(ready, 1'b0);
    repeat (6) @(negedge clk_i);
    chk(seen, 0);
    want = 1'b1;
    take(wpt_pkg::KIND_DIRECT, 4'h0, 1'b1, 1'b0);
    take(wpt_pkg::KIND_INDIRECT, 4'h0, 1'b1, 1'b0);
    @(negedge clk_i);
    chk(pend, 2);
    flush = 1'b1;
    @(negedge clk_i);
    flush = 1'b0;
    chk(disc, 1'b1);
    chk(empty, 1'b1);
    @(negedge clk_i);
    chk(pend, 0);
  endtask : gate_flush
  task automatic codes_test();
    logic [3:0] codes [11] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    foreach (codes[i]) begin
      push(wpt_pkg::KIND_EXCEPT, codes[i], 1'b1);
      take(wpt_pkg::KIND_EXCEPT, codes[i], 1'b1, 1'b1);
      chk(empty, 1'b1);
    end
  endtask : codes_test
  // A commit that lands with the pop shows valid and count in one cycle.
  task automatic same_cycle();
    push(wpt_pkg::KIND_INDIRECT, 4'h3, 1'b0);
    commit = 1'b1;
    @(negedge clk_i);
    commit = 1'b0;
    chk(wv, 1'b1);
    chk(cc, 2'h1);
    chk(empty, 1'b1);
    chk(link, 1'b0);
    @(negedge clk_i);
    chk(pend, 0);
  endtask : same_cycle
  // Words held back by a low enable are uncommitted, so a flush drops them too.
  task automatic flush_held();
    want = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(seen, 14);
    push(wpt_pkg::KIND_DIRECT, 4'h6, 1'b1);
    push(wpt_pkg::KIND_DIRECT, 4'h7, 1'b1);
    chk(ready, 1'b0);
    flush = 1'b1;
    @(negedge clk_i);
    flush = 1'b0;
    chk(ready, 1'b1);
    chk(disc, 1'b1);
    want = 1'b1;
    repeat (5) @(negedge clk_i);
    chk(seen, 14);
    chk(empty, 1'b1);
  endtask : flush_held
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    {valid, commit, flush, want} = '0;
    wpt = '0;
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    chk({ready, empty, cc}, 4'hc);
    gate_flush();
    codes_test();
    same_cycle();
    flush_held();
    end_of_test();
  end
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule : waypoint_trace_output_port_tb_top
`default_nettype wire

// file: wpt_pkg.sv
/*
  Package for the waypoint trace output port: waypoint kinds, exception
  codes, the waypoint record carried between core and port, and depths.
  Assumes a single core clock domain shared by every user of the package.
*/
package wpt_pkg;

  // ----------------------------------------------------------------------
  // Waypoint kinds
  // ----------------------------------------------------------------------
  localparam logic [2:0] KIND_DIRECT   = 3'h0;
  localparam logic [2:0] KIND_INDIRECT = 3'h1;
  localparam logic [2:0] KIND_EXCEPT   = 3'h2;

  // ----------------------------------------------------------------------
  // Exception kind codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] EXC_NONE       = 4'h0;
  localparam logic [3:0] EXC_HALT_DEBUG = 4'h1;
  localparam logic [3:0] EXC_SEC_MON    = 4'h2;
  localparam logic [3:0] EXC_IMPR_ABORT = 4'h4;
  localparam logic [3:0] EXC_ENV_TRAP   = 4'h5;
  localparam logic [3:0] EXC_RESET      = 4'h8;
  localparam logic [3:0] EXC_UNDEF      = 4'h9;
  localparam logic [3:0] EXC_SVC        = 4'ha;
  localparam logic [3:0] EXC_PABT_BKPT  = 4'hb;
  localparam logic [3:0] EXC_DABT_WPT   = 4'hc;
  localparam logic [3:0] EXC_IRQ        = 4'he;
  localparam logic [3:0] EXC_FIQ        = 4'hf;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int         NUM_CORES    = 1;
  localparam int         PEND_DEPTH   = 4;
  localparam int         BUF_DEPTH    = 2;
  localparam logic [1:0] COMMIT_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Waypoint record
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  kind;
    logic [31:0] context_tag;
    logic [3:0]  exc_code;
    logic        writes_link;
  } waypoint_t;

endpackage : wpt_pkg
